// ===== logic/pio_pkg.sv
// Purpose: shared constants and carriers of the parallel port block
// Assumes: six ports of eight pins, flat pin index = port*8 + bit
// Notes: pin masks are per variant, bit 0 is pin 0 of the first port
`default_nettype none
package pio_pkg;

    // ******************************************
    // sizes
    // ******************************************
    localparam int NPORT = 6;
    localparam int NPIN = 48;
    localparam int NSRC = 4;

    // ******************************************
    // register map (byte addresses, port register word indices)
    // ******************************************
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_DIR = 2'h1;
    localparam logic [1:0] REG_OPT = 2'h2;
    localparam logic [1:0] REG_BITOP = 2'h3;
    localparam logic [7:0] OFF_MISC = 8'h60;
    localparam logic [7:0] OFF_STAT = 8'h64;
    localparam logic [7:0] OFF_MASK = 8'h68;
    localparam int BITOP_CLR_POS = 8;

    // ******************************************
    // reset values
    // ******************************************
    localparam logic [NPIN-1:0] RST_DIR = 48'h0000_0000_0000;
    localparam logic [NPIN-1:0] RST_OPT = 48'h0000_0000_0000;
    localparam logic [NPIN-1:0] RST_DATA = 48'h0000_0000_0000;
    localparam logic [3:0] RST_MISC = 4'h0;
    localparam logic [NSRC-1:0] RST_MASK = 4'h0;

    // ******************************************
    // sensitivity codes of a two-bit polarity field
    // ******************************************
    localparam logic [1:0] SENS_LOW = 2'h0;
    localparam logic [1:0] SENS_RISE = 2'h1;
    localparam logic [1:0] SENS_FALL = 2'h2;
    localparam logic [1:0] SENS_BOTH = 2'h3;

    // ******************************************
    // pin capability masks, small variant
    // ******************************************
    localparam logic [NPIN-1:0] SM_PRESENT = 48'h0000_003F_FFFF;
    localparam logic [NPIN-1:0] SM_FULL = 48'h0000_003F_FF00;
    localparam logic [NPIN-1:0] SM_SRC0 = 48'h0000_0000_00FF;
    localparam logic [NPIN-1:0] SM_SRC1 = 48'h0000_003F_FF00;

    // ******************************************
    // pin capability masks, large variant
    // ******************************************
    localparam logic [NPIN-1:0] LG_PRESENT = 48'hD7F3_FFFF_FFFF;
    localparam logic [NPIN-1:0] LG_FULL = 48'hD703_FFFF_FF0F;
    localparam logic [NPIN-1:0] LG_SRC0 = 48'h0000_0000_000F;
    localparam logic [NPIN-1:0] LG_SRC1 = 48'h0700_0000_0000;
    localparam logic [NPIN-1:0] LG_SRC2 = 48'h0000_0000_0F00;
    localparam logic [NPIN-1:0] LG_SRC3 = 48'h0000_0000_F000;

    // ******************************************
    // carriers
    // ******************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } pio_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pio_apb_rsp_type;

    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe;
        logic [NPIN-1:0] pu;
    } pio_drive_type;

endpackage
`default_nettype wire

// ===== logic/pio_irq_group.sv
// Purpose: sensitivity detector of one external interrupt source
// Assumes: lvl_in is the wired-and of the enabled member pins
// Notes: a group with no member enabled rests high
`default_nettype none
module pio_irq_group (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] sens,
    input wire logic lvl_in,
    output logic hit
);
    import pio_pkg::*;

    logic prev_r;

    // ******************************************
    // detection
    // ******************************************
    // low level also covers the falling edge itself
    assign hit = (sens == SENS_LOW) ? ~lvl_in :
                 (sens == SENS_RISE) ? (lvl_in & ~prev_r) :
                 (sens == SENS_FALL) ? (~lvl_in & prev_r) :
                 (lvl_in ^ prev_r);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= lvl_in;
        end
    end

    // ******************************************
    // checks
    // ******************************************
    a_rise_detect: assert property (@(posedge sys_clk) disable iff (rst)
        (sens == SENS_RISE) && lvl_in && !$past(lvl_in) |-> hit)
        else $error("rising edge missed");
    a_fall_detect: assert property (@(posedge sys_clk) disable iff (rst)
        (sens == SENS_FALL) && hit |-> !lvl_in && $past(lvl_in))
        else $error("falling hit without edge");

endmodule
`default_nettype wire

// ===== logic/pio_port.sv
// Purpose: bit-configurable parallel ports with grouped pin interrupts
// Assumes: APB slave, 32-bit data, one wait state on every access
// Notes: LARGE_VARIANT selects the six-port layout, else three ports
`default_nettype none
module pio_port #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pio_pkg::pio_apb_req_type apb_req,
    output pio_pkg::pio_apb_rsp_type apb_rsp,
    input wire logic [pio_pkg::NPIN-1:0] pin_in,
    output pio_pkg::pio_drive_type pin_drv,
    input wire logic [pio_pkg::NPIN-1:0] alt_oe,
    input wire logic [pio_pkg::NPIN-1:0] alt_out,
    output logic [pio_pkg::NPIN-1:0] alt_in,
    output logic [pio_pkg::NSRC-1:0] ext_irq_src,
    output logic irq
);
    import pio_pkg::*;

    // ******************************************
    // capability functions
    // ******************************************
    function automatic logic [NPIN-1:0] src_mask(input int k);
        logic [NPIN-1:0] m;
        m = '0;
        if (LARGE_VARIANT) begin
            unique case (k)
                0: m = LG_SRC0;
                1: m = LG_SRC1;
                2: m = LG_SRC2;
                default: m = LG_SRC3;
            endcase
        end else if (k == 0) begin
            m = SM_SRC0;
        end else if (k == 1) begin
            m = SM_SRC1;
        end
        return m;
    endfunction

    // which polarity pair steers a source
    function automatic logic pol_upper(input int k);
        return LARGE_VARIANT ? (k >= 2) : (k != 0);
    endfunction

    localparam logic [NPIN-1:0] PRESENT =
        LARGE_VARIANT ? LG_PRESENT : SM_PRESENT;
    // pins with pull-up and push-pull; the others are open drain only
    localparam logic [NPIN-1:0] FULL = LARGE_VARIANT ? LG_FULL : SM_FULL;

    // ******************************************
    // state
    // ******************************************
    logic [NPIN-1:0] dir_r, opt_r, data_r;
    logic [NPIN-1:0] dir_nxt, opt_nxt, data_nxt;
    logic [NPIN-1:0] pin_s1_r;
    logic [3:0] misc_r, misc_nxt;
    logic [NSRC-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic [NSRC-1:0] hit;
    logic [NSRC-1:0] grp_lvl;
    logic [NSRC-1:0] grp_en;
    pio_drive_type drv_nxt;
    pio_apb_rsp_type rsp_nxt;

    // ******************************************
    // APB decode
    // ******************************************
    wire access = apb_req.psel & apb_req.penable;
    wire commit = access & apb_rsp.pready;
    wire wr = commit & apb_req.pwrite;
    wire [2:0] port_idx = apb_req.paddr[6:4];
    wire [1:0] reg_idx = apb_req.paddr[3:2];
    wire in_ports = (apb_req.paddr[1:0] == 2'h0) &&
                    (apb_req.paddr < (PORT_STRIDE * 8'(NPORT)));
    wire hit_misc = apb_req.paddr == OFF_MISC;
    wire hit_stat = apb_req.paddr == OFF_STAT;
    wire hit_mask = apb_req.paddr == OFF_MASK;
    wire mapped = in_ports | hit_misc | hit_stat | hit_mask;
    wire lane0 = apb_req.pstrb[0];
    wire lane1 = apb_req.pstrb[1];
    wire [7:0] wbyte = apb_req.pwdata[7:0];
    wire [7:0] cbyte = apb_req.pwdata[15:8];

    // per-port read view: latch for outputs, pin for inputs
    wire [NPIN-1:0] data_view = ((dir_r & data_r) | (~dir_r & alt_in))
                                & PRESENT;
    wire [7:0] rd_data = data_view[port_idx*8 +: 8];
    wire [7:0] rd_dir = dir_r[port_idx*8 +: 8];
    wire [7:0] rd_opt = opt_r[port_idx*8 +: 8];
    wire [7:0] rd_port = (reg_idx == REG_DATA) ? rd_data :
                         (reg_idx == REG_DIR) ? rd_dir :
                         (reg_idx == REG_OPT) ? rd_opt : 8'h00;
    wire [31:0] rd_word = in_ports ? {24'h000000, rd_port} :
                          hit_misc ? {28'h0000000, misc_r} :
                          hit_stat ? {28'h0000000, stat_r} :
                          hit_mask ? {28'h0000000, mask_r} : 32'h00000000;

    // ******************************************
    // register writes
    // ******************************************
    wire wr_port = wr & in_ports & lane0;
    wire [NPIN-1:0] sel_port = {{(NPIN-8){1'b0}}, 8'hFF} << (port_idx * 8);
    wire [NPIN-1:0] wide_w = {NPORT{wbyte}} & sel_port;
    wire [NPIN-1:0] wide_c = {NPORT{cbyte & {8{lane1}}}} & sel_port;
    wire wr_data = wr_port & (reg_idx == REG_DATA);
    wire wr_bitop = wr & in_ports & (reg_idx == REG_BITOP);
    wire [NPIN-1:0] bit_set = wide_w & {NPIN{lane0}};

    always_comb begin
        data_nxt = data_r;
        dir_nxt = dir_r;
        opt_nxt = opt_r;
        if (wr_data) begin
            data_nxt = (data_r & ~sel_port) | wide_w;
        end
        if (wr_bitop) begin
            data_nxt = (data_r | bit_set) & ~wide_c;
        end
        if (wr_port && (reg_idx == REG_DIR)) begin
            dir_nxt = ((dir_r & ~sel_port) | wide_w) & PRESENT;
        end
        if (wr_port && (reg_idx == REG_OPT)) begin
            opt_nxt = ((opt_r & ~sel_port) | wide_w) & PRESENT;
        end
    end

    assign misc_nxt = (wr & hit_misc & lane0) ? wbyte[3:0] : misc_r;
    assign mask_nxt = (wr & hit_mask & lane0) ? wbyte[NSRC-1:0] : mask_r;
    // a new event outranks a write-one-to-clear in the same cycle
    wire [NSRC-1:0] w1c = (wr & hit_stat & lane0) ? wbyte[NSRC-1:0] : 4'h0;
    assign stat_nxt = (stat_r & ~w1c) | hit;

    // ******************************************
    // pin drive
    // ******************************************
    wire [NPIN-1:0] eff_dir = (dir_r | alt_oe) & PRESENT;
    wire [NPIN-1:0] eff_val = (alt_oe & alt_out) | (~alt_oe & data_r);
    // push-pull only where the pin can source current
    wire [NPIN-1:0] push = opt_r & FULL;

    always_comb begin
        drv_nxt.oe = eff_dir & (push | ~eff_val);
        drv_nxt.out = eff_val & push;
        drv_nxt.pu = ~eff_dir & opt_r & FULL;
    end

    // ******************************************
    // interrupt groups
    // ******************************************
    // input, option set and capable: only these feed a group
    wire [NPIN-1:0] irq_pin = ~eff_dir & opt_r & PRESENT;

    genvar k;
    generate
        for (k = 0; k < NSRC; k++) begin : g_src
            wire [NPIN-1:0] members = irq_pin & src_mask(k);
            wire [1:0] sens = pol_upper(k) ? misc_r[3:2] : misc_r[1:0];
            // wired-and: any enabled member low pulls the group low
            assign grp_lvl[k] = &(alt_in | ~members);
            assign grp_en[k] = |members;
            pio_irq_group u_grp (
                .sys_clk(sys_clk),
                .rst(rst),
                .sens(sens),
                .lvl_in(grp_lvl[k]),
                .hit(hit[k])
            );
        end
    endgenerate

    // ******************************************
    // response
    // ******************************************
    always_comb begin
        rsp_nxt.pready = access & ~apb_rsp.pready;
        rsp_nxt.prdata = (access & ~apb_rsp.pready & ~apb_req.pwrite) ?
                         rd_word : 32'h00000000;
        rsp_nxt.pslverr = access & ~apb_rsp.pready & ~mapped;
    end

    // ******************************************
    // flops
    // ******************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dir_r <= RST_DIR;
            opt_r <= RST_OPT;
            data_r <= RST_DATA;
            misc_r <= RST_MISC;
            mask_r <= RST_MASK;
            stat_r <= '0;
        end else begin
            dir_r <= dir_nxt;
            opt_r <= opt_nxt;
            data_r <= data_nxt;
            misc_r <= misc_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
        end
    end

    // pins are asynchronous: two stages before any use
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= '0;
            alt_in <= '0;
        end else begin
            pin_s1_r <= pin_in;
            alt_in <= pin_s1_r;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_drv <= '0;
            apb_rsp <= '0;
            ext_irq_src <= '0;
            irq <= 1'b0;
        end else begin
            pin_drv <= drv_nxt;
            apb_rsp <= rsp_nxt;
            ext_irq_src <= stat_r & mask_r;
            irq <= |(stat_r & mask_r);
        end
    end

    // ******************************************
    // checks
    // ******************************************
    a_input_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
        (pin_drv.oe & ~$past(eff_dir)) == '0)
        else $error("input pin driven");
    a_od_never_high: assert property (@(posedge sys_clk) disable iff (rst)
        (pin_drv.out & ~$past(push)) == '0)
        else $error("open drain pin drives high");
    a_pullup_capable: assert property (@(posedge sys_clk) disable iff (rst)
        (pin_drv.pu & ~FULL) == '0)
        else $error("pull-up on incapable pin");
    a_stat_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
        hit[0] |=> stat_r[0])
        else $error("source event lost");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 irq == |($past(stat_r) & $past(mask_r)))
        else $error("interrupt level wrong");
    a_idle_group_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !grp_en[0] && !$past(grp_en[0]) |-> !hit[0])
        else $error("empty group raised event");
    a_apb_one_wait: assert property (@(posedge sys_clk) disable iff (rst)
        access && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("apb answer late");
    a_alt_handover: assert property (@(posedge sys_clk) disable iff (rst)
        ((pin_drv.out ^ $past(alt_out)) & $past(alt_oe & push)) == '0)
        else $error("peripheral output not passed");
    a_dir_reset: assert property (@(posedge sys_clk)
        $fell(rst) |-> dir_r == '0 && opt_r == '0)
        else $error("config not cleared by reset");

    c_write_dir: cover property (@(posedge sys_clk) disable iff (rst)
        wr_port && reg_idx == REG_DIR);
    c_irq_raised: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(irq));
    c_alt_take: cover property (@(posedge sys_clk) disable iff (rst)
        |(alt_oe & dir_r));
    c_unmapped: cover property (@(posedge sys_clk) disable iff (rst)
        apb_rsp.pslverr);

endmodule
`default_nettype wire

// ===== tb/pio_board.sv
// Purpose: board model of the signals around the port pins
// Assumes: block drive wins over the board driver when both are on
// Notes: an undriven pin without pull-up toggles every cycle
`default_nettype none
module pio_board (
    input wire logic sys_clk,
    input wire pio_pkg::pio_drive_type drv,
    input wire logic [pio_pkg::NPIN-1:0] ext_en,
    input wire logic [pio_pkg::NPIN-1:0] ext_val,
    output logic [pio_pkg::NPIN-1:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;
    // ******************************************
    // pin resolution
    // ******************************************
    // floating pin has no stable level, so no lucky zero from the tool
    logic [NPIN-1:0] float_r = '0;
    always @(posedge sys_clk) begin
        float_r <= ~float_r;
    end
    assign pin_lvl = (drv.oe & drv.out) | (~drv.oe & ext_en & ext_val)
        | (~drv.oe & ~ext_en & (drv.pu | float_r));
endmodule
`default_nettype wire

// ===== tb/pio_port_tb.sv
// Purpose: self-checking bench of the parallel port block
// Assumes: small layout, one wait state on the register bus
// Notes: the six-port layout masks are not exercised here
`default_nettype none
module pio_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    pio_apb_req_type req = '0;
    pio_apb_rsp_type rsp;
    pio_drive_type drv;
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] ext_en = '0;
    logic [NPIN-1:0] ext_val = '0;
    logic [NPIN-1:0] alt_oe = '0;
    logic [NPIN-1:0] alt_out = '0;
    logic [NPIN-1:0] alt_in;
    logic [NSRC-1:0] src;
    logic irq;
    logic [31:0] rdata;
    logic rerr;
    int errors = 0;
    int n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    pio_port #(.LARGE_VARIANT(1'b0)) i_pio_port (
        .sys_clk(sys_clk),
        .rst(rst),
        .apb_req(req),
        .apb_rsp(rsp),
        .pin_in(pin_lvl),
        .pin_drv(drv),
        .alt_oe(alt_oe),
        .alt_out(alt_out),
        .alt_in(alt_in),
        .ext_irq_src(src),
        .irq(irq)
    );
    pio_board i_pio_board (
        .sys_clk(sys_clk),
        .drv(drv),
        .ext_en(ext_en),
        .ext_val(ext_val),
        .pin_lvl(pin_lvl)
    );
    // ******************************************
    // helpers
    // ******************************************
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        req.pstrb <= 4'hF;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            wrap_up();
        end
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // ******************************************
    // scenarios
    // ******************************************
    task automatic t_reset();
        for (int p = 0; p < 3; p++) begin
            rd(8'(p * 16 + 4));
            check(48'(rdata), 48'h0);
            rd(8'(p * 16 + 8));
            check(48'(rdata), 48'h0);
        end
        check(drv.oe, 48'h0);
        check(drv.pu, 48'h0);
        rd(OFF_MISC);
        check(48'(rdata), 48'h0);
        rd(8'h70);
        check(48'(rerr), 48'h1);
        check(48'(rdata), 48'h0);
    endtask
    task automatic t_output();
        wr(8'h14, 32'h0000_00FF);
        wr(8'h18, 32'h0000_000F);
        wr(8'h10, 32'h0000_00A5);
        cyc(2);
        check(48'(drv.oe[15:8]), 48'h5F);
        check(48'(drv.out[15:8] & drv.oe[15:8]), 48'h05);
        rd(8'h10);
        check(48'(rdata[7:0]), 48'hA5);
        wr(8'h1C, 32'h0000_210A);
        rd(8'h10);
        check(48'(rdata[7:0]), 48'h8E);
        check(48'(drv.oe[15:8]), 48'h7F);
        check(48'(drv.out[15:8] & drv.oe[15:8]), 48'h0E);
    endtask
    task automatic t_open_drain();
        wr(8'h04, 32'h0000_00FF);
        wr(8'h08, 32'h0000_00FF);
        wr(8'h00, 32'h0000_000F);
        cyc(2);
        check(48'(drv.oe[7:0]), 48'hF0);
        check(48'(drv.out[7:0] & drv.oe[7:0]), 48'h00);
        // board drives high, but pins 4-7 read low until the drive lets go
        ext_en[7:0] <= 8'hFF;
        ext_val[7:0] <= 8'hFF;
        wr(8'h04, 32'h0000_0000);
        wr(8'h28, 32'h0000_003F);
        cyc(2);
        check(48'(drv.pu[7:0]), 48'h00);
        check(48'(drv.oe[7:0]), 48'h00);
        check(48'(drv.pu[23:8]), 48'h3F00);
    endtask
    task automatic t_irq();
        wr(8'h08, 32'h0000_0001);
        wr(OFF_MASK, 32'h0000_0001);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_MISC, 32'(c));
            cyc(8);
            wr(OFF_STAT, 32'h0000_000F);
            rd(OFF_STAT);
            check(48'(rdata[0]), 48'h0);
            ext_val[0] <= 1'b0;
            cyc(8);
            rd(OFF_STAT);
            check(48'(rdata[0]), 48'(c != 1));
            check(48'(irq), 48'(c != 1));
            wr(OFF_STAT, 32'h0000_000F);
            ext_val[0] <= 1'b1;
            cyc(8);
            rd(OFF_STAT);
            check(48'(rdata[0]), 48'(c != 2));
        end
        check(48'(src), 48'h1);
        wr(OFF_MASK, 32'h0000_0000);
        cyc(2);
        check(48'(irq), 48'h0);
        rd(OFF_STAT);
        check(48'(rdata[3:0]), 48'h1);
    endtask
    task automatic t_group1();
        ext_en[18] <= 1'b1;
        ext_val[18] <= 1'b1;
        wr(8'h14, 32'h0000_0000);
        wr(8'h18, 32'h0000_0008);
        wr(OFF_MISC, 32'h0000_0008);
        wr(OFF_MASK, 32'h0000_0003);
        cyc(8);
        wr(OFF_STAT, 32'h0000_000F);
        ext_val[18] <= 1'b0;
        cyc(8);
        rd(OFF_STAT);
        check(48'(rdata[3:0]), 48'h2);
        check(48'(src), 48'h2);
        wr(OFF_STAT, 32'h0000_000F);
        ext_val[18] <= 1'b1;
        cyc(8);
        rd(OFF_STAT);
        check(48'(rdata[3:0]), 48'h0);
    endtask
    task automatic t_alt();
        alt_oe[16] <= 1'b1;
        alt_out[16] <= 1'b1;
        cyc(5);
        check(48'(drv.oe[16]), 48'h1);
        check(48'(drv.out[16]), 48'h1);
        check(48'(alt_in[16]), 48'h1);
        alt_out[16] <= 1'b0;
        cyc(5);
        check(48'(drv.out[16]), 48'h0);
        check(48'(alt_in[16]), 48'h0);
    endtask
    // ******************************************
    // main sequence
    // ******************************************
    initial begin
        cyc(10);
        rst <= 1'b0;
        t_reset();
        t_output();
        t_open_drain();
        t_irq();
        t_group1();
        t_alt();
        wrap_up();
    end
endmodule
`default_nettype wire
